//--- shared/dcr_pkg.sv
// constants for the deserializer configuration register bank
package dcr_pkg;
  // register offsets on the management bus
  localparam logic [7:0] DCR_OFS_ADDR     = 8'h00;
  localparam logic [7:0] DCR_OFS_RESET    = 8'h01;
  localparam logic [7:0] DCR_OFS_PIN0_CFG = 8'h02;
  // field positions
  localparam int DCR_ADDR_MSB  = 7;
  localparam int DCR_ADDR_LSB  = 1;
  localparam int DCR_SRST_BIT  = 0;
  localparam int DCR_MODE_MSB  = 7;
  localparam int DCR_MODE_LSB  = 4;
  localparam int DCR_PULL_MSB  = 3;
  localparam int DCR_PULL_LSB  = 2;
  localparam int DCR_IBUF_BIT  = 1;
  localparam int DCR_OEN_BIT   = 0;
  // reset values
  localparam logic [7:0] DCR_PIN0_CFG_RST = 8'h05;
  localparam logic       DCR_SRST_RST     = 1'b0;
  // output source codes
  localparam logic [3:0] DCR_MODE_GENERAL_OUTPUT_VALUE   = 4'h0;
  localparam logic [3:0] DCR_MODE_SIGDET  = 4'h1;
  // pull resistor codes
  localparam logic [1:0] DCR_PULL_NONE    = 2'h0;
  localparam logic [1:0] DCR_PULL_DOWN    = 2'h1;
  localparam logic [1:0] DCR_PULL_UP      = 2'h2;
  // bus framing
  localparam logic [3:0] DCR_BITS_PER_BYTE = 4'h8;
endpackage

//--- hw/dcr_top.sv
// management bus slave and configuration registers of the deserializer
`timescale 1ns/1ns
`default_nettype none
module dcr_top
  import dcr_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR_RST = 7'h2a  // arbitrary power-up address
) (
  input  wire logic CORE_CLK_I,
  input  wire logic SRST_I,
  input  wire logic BUS_CHIP_SELECT_I,
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_O,
  input  wire logic GENERAL_OUTPUT_VALUE_I,
  input  wire logic SIGNAL_DETECT0_I,
  input  wire logic PIN0_I,
  output logic      PIN0_O,
  output logic      PIN0_OE_O,
  output logic      PIN0_PULLUP_O,
  output logic      PIN0_PULLDOWN_O,
  output logic      PIN0_IN_O,
  output logic      SOFT_RESET_O
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } dcr_state_type;

  dcr_state_type state;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] cs_s;
  logic [1:0] sd_s;
  logic [1:0] pin_s;
  logic       scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic       rd_mode;
  logic [7:0] ptr;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] bus_address_field;
  logic       soft_reset_bit;
  logic [7:0] pin0_config;
  logic       sda_oe;
  logic [7:0] rd_byte;

  // register read mux, also used when preloading each read byte
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      DCR_OFS_ADDR:     v = {bus_address_field, 1'b0};
      DCR_OFS_RESET:    v = {7'h00, soft_reset_bit};
      DCR_OFS_PIN0_CFG: v = pin0_config;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // byte about to be shifted out on a read, taken from the current pointer
  always_comb begin
    rd_byte = read_reg(ptr);
  end

  // two-flop synchronisers plus one history stage for bus edges
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      cs_s  <= 2'h0;
      sd_s  <= 2'h0;
      pin_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], SCL_I};
      sda_s <= {sda_s[1:0], SDA_I};
      cs_s  <= {cs_s[0], BUS_CHIP_SELECT_I};
      sd_s  <= {sd_s[0], SIGNAL_DETECT0_I};
      pin_s <= {pin_s[0], PIN0_I};
    end
  end

  // bus events, seen only on synchronised stages
  assign scl_rise   = scl_s[1] & ~scl_s[2];
  assign scl_fall   = ~scl_s[1] & scl_s[2];
  assign start_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_cond  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // byte-level bus slave: address, pointer, then data with auto-increment
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state   <= ST_IDLE;
      shreg   <= 8'h00;
      bit_cnt <= 4'h0;
      rd_mode <= 1'b0;
      ptr     <= 8'h00;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (!cs_s[1]) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RACK: begin
            if (sda_s[1]) begin
              state <= ST_IDLE;                       // master ended the read
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == DCR_BITS_PER_BYTE) begin
              if (shreg[7:1] == bus_address_field) begin
                rd_mode <= shreg[0];
                sda_oe  <= 1'b1;
                state   <= ST_ADDR_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (bit_cnt == DCR_BITS_PER_BYTE) begin
              ptr    <= shreg;
              sda_oe <= 1'b1;
              state  <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bit_cnt == DCR_BITS_PER_BYTE) begin
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h01;
              sda_oe  <= 1'b1;
              state   <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              shreg  <= {rd_byte[6:0], 1'b0};
              sda_oe <= ~rd_byte[7];
              ptr    <= ptr + 8'h01;
              bit_cnt <= 4'h1;
              state  <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_PTR;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt == DCR_BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state  <= ST_RACK;
            end else begin
              sda_oe  <= ~shreg[7];
              shreg   <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RACK: begin
            shreg   <= {rd_byte[6:0], 1'b0};
            sda_oe  <= ~rd_byte[7];
            ptr     <= ptr + 8'h01;
            bit_cnt <= 4'h1;
            state   <= ST_RDATA;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // bus address register, untouched by the soft reset
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      bus_address_field <= BUS_ADDR_RST;
    end else if (wr_en && wr_addr == DCR_OFS_ADDR) begin
      bus_address_field <= wr_data[DCR_ADDR_MSB:DCR_ADDR_LSB];
    end
  end

  // soft reset bit: a written one restores the pin configuration reset value and clears itself
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I || soft_reset_bit) begin
      soft_reset_bit <= DCR_SRST_RST;
    end else if (wr_en && wr_addr == DCR_OFS_RESET) begin
      soft_reset_bit <= wr_data[DCR_SRST_BIT];
    end
  end

  // pin configuration register
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I || soft_reset_bit) begin
      pin0_config <= DCR_PIN0_CFG_RST;
    end else if (wr_en && wr_addr == DCR_OFS_PIN0_CFG) begin
      pin0_config <= wr_data;
    end
  end

  // registered pin drive, pulls, input buffer and bus outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      PIN0_O          <= 1'b0;
      PIN0_OE_O       <= 1'b0;
      PIN0_PULLUP_O   <= 1'b0;
      PIN0_PULLDOWN_O <= 1'b0;
      PIN0_IN_O       <= 1'b0;
      SDA_O           <= 1'b0;
      SDA_OE_O        <= 1'b0;
      SOFT_RESET_O    <= 1'b0;
    end else begin
      case (pin0_config[DCR_MODE_MSB:DCR_MODE_LSB])
        DCR_MODE_GENERAL_OUTPUT_VALUE:  PIN0_O <= GENERAL_OUTPUT_VALUE_I;
        DCR_MODE_SIGDET: PIN0_O <= sd_s[1];
        default:         PIN0_O <= 1'b0;                       // reserved codes
      endcase
      PIN0_OE_O       <= pin0_config[DCR_OEN_BIT];
      PIN0_PULLDOWN_O <= pin0_config[DCR_PULL_MSB:DCR_PULL_LSB]
                         == DCR_PULL_DOWN;
      PIN0_PULLUP_O   <= pin0_config[DCR_PULL_MSB:DCR_PULL_LSB]
                         == DCR_PULL_UP;
      PIN0_IN_O       <= pin0_config[DCR_IBUF_BIT] & pin_s[1];
      SDA_O           <= 1'b0;
      SDA_OE_O        <= sda_oe;
      SOFT_RESET_O    <= soft_reset_bit;
    end
  end

endmodule
`default_nettype wire

//--- tb/dcr_checker.sv
// port assertions for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module dcr_checker (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic BUS_CHIP_SELECT_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic PIN0_OE_O,
  input wire logic PIN0_PULLUP_O,
  input wire logic PIN0_PULLDOWN_O,
  input wire logic PIN0_IN_O,
  input wire logic SOFT_RESET_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // pin settings restored by power-up and by soft reset
  sequence s_cfg_dflt;
    PIN0_OE_O && PIN0_PULLDOWN_O && !PIN0_PULLUP_O && !PIN0_IN_O;
  endsequence
  // outputs quiet one edge after reset
  AST_RST_QUIET: assert property (disable iff (1'b0) SRST_I |=>
    !PIN0_OE_O && !SDA_OE_O && !SOFT_RESET_O) else $error("reset leak");
  AST_RST_VALUES: assert property ($fell(SRST_I) |-> ##[1:3] s_cfg_dflt)
    else $error("pin defaults wrong");
  AST_IBUF_OFF: assert property ($fell(SRST_I) |-> !PIN0_IN_O [*4])
    else $error("input buffer on at reset");
  AST_PULL_EXCL: assert property (!(PIN0_PULLUP_O && PIN0_PULLDOWN_O))
    else $error("both pulls on");
  AST_SRST_PULSE: assert property ($rose(SOFT_RESET_O) |=> !SOFT_RESET_O)
    else $error("soft reset pulse too long");
  AST_SRST_RESTORE: assert property (SOFT_RESET_O |-> ##[0:2] s_cfg_dflt)
    else $error("soft reset kept pin setup");
  AST_CS_IDLE: assert property (!BUS_CHIP_SELECT_I [*6] |-> !SDA_OE_O)
    else $error("bus driven while deselected");
  AST_OPEN_DRAIN: assert property (!SDA_O)
    else $error("data driven high");
endmodule
bind dcr_top dcr_checker chk (.CORE_CLK_I, .SRST_I, .BUS_CHIP_SELECT_I,
  .SDA_O, .SDA_OE_O, .PIN0_OE_O, .PIN0_PULLUP_O, .PIN0_PULLDOWN_O,
  .PIN0_IN_O, .SOFT_RESET_O);
`default_nettype wire

//--- tb/dcr_host.sv
// host model: bit-banged two-wire management master
`timescale 1ns/1ns
`default_nettype none
module dcr_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // bus idles with clock high and data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // half bus period, kept above the ten-clock minimum
  task hp;
    repeat (12) @(posedge clk_i);
    #1;
  endtask
  // start or repeated start: data falls while clock is high
  task st;
    sda_low_o = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_low_o = 1'b1;
    hp;
    scl_o = 1'b0;
  endtask
  // stop: data rises while clock is high
  task sp;
    sda_low_o = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_low_o = 1'b0;
    hp;
  endtask
  // eight bits msb first plus acknowledge, sampled late in clock high
  task x9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low_o = !d[i];
      hp;
      scl_o = 1'b1;
      hp;
      q[i] = sda_i;
      scl_o = 1'b0;
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] p, d, output logic nak);
    logic [8:0] q0, q1, q2;
    st;
    x9({a, 2'b01}, q0);
    x9({p, 1'b1}, q1);
    x9({d, 1'b1}, q2);
    sp;
    nak = q0[0] | q1[0] | q2[0];
  endtask
  task rd(input logic [6:0] a, input logic [7:0] p,
          output logic [7:0] d, output logic nak);
    logic [8:0] q0, q1, q2, q3;
    st;
    x9({a, 2'b01}, q0);
    x9({p, 1'b1}, q1);
    st;
    x9({a, 2'b11}, q2);
    x9(9'h1ff, q3);
    sp;
    d = q3[8:1];
    nak = q0[0] | q1[0] | q2[0];
  endtask
endmodule
`default_nettype wire

//--- tb/test_des_config_registers.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module test_des_config_registers;
  import dcr_pkg::*;
  localparam logic [6:0] A0 = 7'h2a;
  localparam logic [6:0] A1 = 7'h36;
  // rows: pin setup, {gp, sd, pin}, {pullup, pulldown, oe, in, out}
  localparam logic [15:0] ROWS [8] = '{16'h0185, 16'h1145, 16'h1184,
    16'h0914, 16'h062a, 16'h0200, 16'h0c00, 16'h2184};
  logic       clk = 1'b0, srst = 1'b1, cs = 1'b1;
  logic       gp = 1'b0, sd = 1'b0, pin = 1'b0;
  logic       sda_oe, sda_o, h_low, scl, nak, sr;
  logic [7:0] d;
  wire logic [4:0] got;
  int         mismatches = 0, n_tests = 0, cyc = 0, n_sr = 0;
  wire logic  sda = !(h_low || sda_oe);
  dcr_top dut (.CORE_CLK_I(clk), .SRST_I(srst), .BUS_CHIP_SELECT_I(cs),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .GENERAL_OUTPUT_VALUE_I(gp), .SIGNAL_DETECT0_I(sd), .PIN0_I(pin),
    .PIN0_O(got[0]), .PIN0_OE_O(got[2]), .PIN0_PULLUP_O(got[4]),
    .PIN0_PULLDOWN_O(got[3]), .PIN0_IN_O(got[1]), .SOFT_RESET_O(sr));
  dcr_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(h_low));
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // soft reset pulse count and hang guard
  always @(posedge clk) begin
    n_sr <= n_sr + int'(sr);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      test_done;
    end
  end
  task chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task rc(input logic [6:0] a, input logic [7:0] p, e, input string nm);
    host.rd(a, p, d, nak);
    chk(nm, e, d);
    chk({nm, " ack"}, 8'h00, {7'h0, nak});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    rc(A0, DCR_OFS_ADDR, {A0, 1'b0}, "addr");
    rc(A0, DCR_OFS_RESET, 8'h00, "rst reg");
    rc(A0, DCR_OFS_PIN0_CFG, DCR_PIN0_CFG_RST, "cfg");
    rc(A0, 8'h03, 8'h00, "unmapped");
    $display("test reset values done");
    foreach (ROWS[i]) begin
      {gp, sd, pin} = ROWS[i][7:5];
      host.wr(A0, DCR_OFS_PIN0_CFG, ROWS[i][15:8], nak);
      chk("wr ack", 8'h00, {7'h0, nak});
      repeat (8) @(posedge clk);
      #1;
      chk("pins", {3'h0, ROWS[i][4:0]}, {3'h0, got});
      rc(A0, DCR_OFS_PIN0_CFG, ROWS[i][15:8], "cfg rb");
    end
    $display("test pin table done");
    host.wr(A0, DCR_OFS_RESET, 8'hfe, nak);
    rc(A0, DCR_OFS_RESET, 8'h00, "rst rsvd");
    host.wr(A0, DCR_OFS_ADDR, {A1, 1'b0}, nak);
    rc(A1, DCR_OFS_ADDR, {A1, 1'b0}, "new addr");
    host.rd(A0, DCR_OFS_ADDR, d, nak);
    chk("old addr nak", 8'h01, {7'h0, nak});
    host.wr(A1, DCR_OFS_PIN0_CFG, 8'h09, nak);
    host.wr(A1, DCR_OFS_RESET, 8'h01, nak);
    chk("pulses", 8'h01, 8'(n_sr));
    rc(A1, DCR_OFS_PIN0_CFG, DCR_PIN0_CFG_RST, "cfg srst");
    rc(A1, DCR_OFS_ADDR, {A1, 1'b0}, "addr kept");
    $display("test address and soft reset done");
    cs = 1'b0;
    host.rd(A1, DCR_OFS_ADDR, d, nak);
    chk("deselected", 8'h01, {7'h0, nak});
    cs = 1'b1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    rc(A0, DCR_OFS_ADDR, {A0, 1'b0}, "addr reset");
    $display("test select and reset done");
    test_done;
  end
endmodule
`default_nettype wire
